// [rtl/txfc_device.sv]
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Function
// - buffers full: ready drops only after packet
// - back-to-back while full: ready drops after last
// - first beat accepted means whole packet accepted
// - source keeps payload within programmed maximum; txfc_source does not check MAX_BEATS
// - ready withdrawn only for three reasons
// - granted self-generated packet holds ready low
// - non-D0 power: finish packet, then ready low
// - source holds signals stable while ready low
// - discontinue counts only with valid and ready
// - source never discontinues on first beat
// - discontinue ignored outside a packet
// - discontinue: discard, or end bad when cut-through
// - discard on link down, oversize, cut-through gap
// - keep accepting; drop flag within three cycles
// - source may set header poison bit itself
// - poison request on any beat sets poison
// - source never poisons cut-through packets
// - cut-through: flag whole packet, valid every beat; txfc_source drops valid for one cycle mid-packet when CTRL_GAP is set
// - throttled cut-through: drop, flag, nullify
// - source grants core packet one cycle after
// - packets start on a new beat
module txfc_device (
  input  wire logic                        SYS_CLK,
  input  wire logic                        RSTN,
  txfc_if.dev                              TX,
  input  wire logic                        BUF_AVAIL,
  input  wire logic                        LINK_UP,
  input  wire logic                        PWR_D0,
  input  wire logic                        CORE_PKT_PEND,
  input  wire logic [txfc_pkg::BEAT_W-1:0] MAX_BEATS,
  output logic                             LNK_VALID,
  output logic [txfc_pkg::DATA_W-1:0]      LNK_DATA,
  output logic [txfc_pkg::KEEP_W-1:0]      LNK_KEEP,
  output logic                             LNK_LAST,
  output logic                             LNK_CUT,
  output logic                             LNK_EP,
  output logic                             LNK_DISCARD,
  output logic                             LNK_EDB,
  output logic                             CORE_PKT_SENT
);

  txfc_pkg::txfc_dev_state_type state_reg;
  txfc_pkg::txfc_dev_state_type state_next;

  logic                        tready_reg;
  logic                        tready_next;
  logic                        cfg_req_reg;
  logic                        err_drop_reg;
  logic                        in_pkt_reg;
  logic                        in_pkt_next;
  logic                        cut_reg;
  logic                        bad_reg;
  logic                        poison_reg;
  logic [txfc_pkg::BEAT_W-1:0] beats_reg;
  logic [7:0]                  core_cnt_reg;

  logic beat_acc;
  logic first_beat;
  logic dsc_hit;
  logic pkt_end;
  logic cut_now;
  logic throttled;
  logic oversize;
  logic bad_now;
  logic poison_now;
  logic core_start;
  logic core_done;

  assign TX.tready   = tready_reg;
  assign TX.cfg_req  = cfg_req_reg;
  assign TX.err_drop = err_drop_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // packet tracking

  assign beat_acc   = TX.tvalid & tready_reg;
  assign first_beat = beat_acc & ~in_pkt_reg;
  // a discontinue on a first beat or between packets has no effect
  assign dsc_hit    = beat_acc & in_pkt_reg & TX.tuser[txfc_pkg::USER_DSC];
  // a discontinue ends the packet whether or not last comes with it
  assign pkt_end    = beat_acc & (TX.tlast | dsc_hit);
  assign cut_now    = first_beat ? TX.tuser[txfc_pkg::USER_STR] : cut_reg;
  // valid gap inside a cut-through packet
  assign throttled  = in_pkt_reg & cut_reg & ~TX.tvalid;
  assign oversize   = beat_acc & ((first_beat ? txfc_pkg::BEATS_ZERO : beats_reg) >= MAX_BEATS);
  assign bad_now    = (~first_beat & bad_reg) | throttled | oversize
                    | ((in_pkt_reg | beat_acc) & ~LINK_UP);
  assign poison_now = (~first_beat & poison_reg)
                    | (beat_acc & TX.tuser[txfc_pkg::USER_FWD]);

  always_comb begin
    in_pkt_next = in_pkt_reg;
    if (pkt_end) begin
      in_pkt_next = 1'b0;
    end else if (first_beat) begin
      in_pkt_next = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      in_pkt_reg <= 1'b0;
      cut_reg    <= 1'b0;
      bad_reg    <= 1'b0;
      poison_reg <= 1'b0;
    end else begin
      in_pkt_reg <= in_pkt_next;
      cut_reg    <= cut_now;
      bad_reg    <= bad_now;
      poison_reg <= poison_now;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      beats_reg <= txfc_pkg::BEATS_ZERO;
    end else if (first_beat) begin
      beats_reg <= txfc_pkg::BEATS_ONE;
    end else if (beat_acc && beats_reg != txfc_pkg::BEATS_MAX) begin
      beats_reg <= beats_reg + txfc_pkg::BEATS_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // self-generated packets

  // the grant is only honoured between packets so user beats never interleave
  // the pending flag may still stand in the cycle that reports the send
  assign core_start = (state_reg == txfc_pkg::TXFC_DEV_IDLE) & CORE_PKT_PEND
                    & TX.cfg_gnt & ~in_pkt_next & ~CORE_PKT_SENT;
  assign core_done  = (state_reg == txfc_pkg::TXFC_DEV_CORE)
                    & (core_cnt_reg == txfc_pkg::CYCLES_ONE);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      txfc_pkg::TXFC_DEV_IDLE: begin
        if (core_start) begin
          state_next = txfc_pkg::TXFC_DEV_CORE;
        end
      end
      txfc_pkg::TXFC_DEV_CORE: begin
        if (core_done) begin
          state_next = txfc_pkg::TXFC_DEV_IDLE;
        end
      end
      default: begin
        state_next = txfc_pkg::TXFC_DEV_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= txfc_pkg::TXFC_DEV_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      core_cnt_reg <= txfc_pkg::CYCLES_ZERO;
    end else if (core_start) begin
      core_cnt_reg <= txfc_pkg::CORE_PKT_CYCLES;
    end else if (core_cnt_reg != txfc_pkg::CYCLES_ZERO) begin
      core_cnt_reg <= core_cnt_reg - txfc_pkg::CYCLES_ONE;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cfg_req_reg   <= 1'b0;
      CORE_PKT_SENT <= 1'b0;
    end else begin
      cfg_req_reg   <= CORE_PKT_PEND & (state_next == txfc_pkg::TXFC_DEV_IDLE)
                     & ~core_done & ~CORE_PKT_SENT;
      CORE_PKT_SENT <= core_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // ready: computed from next-cycle state so a full pool after a last beat
  // removes ready on the very next cycle, never mid-packet

  always_comb begin
    tready_next = 1'b0;
    if (state_next == txfc_pkg::TXFC_DEV_IDLE) begin
      if (in_pkt_next) begin
        tready_next = 1'b1;
      end else begin
        tready_next = BUF_AVAIL & PWR_D0;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      tready_reg <= 1'b0;
    end else begin
      tready_reg <= tready_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // link-side beat stream and end-of-packet verdict

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      LNK_VALID <= 1'b0;
      LNK_DATA  <= '0;
      LNK_KEEP  <= '0;
      LNK_LAST  <= 1'b0;
      LNK_CUT   <= 1'b0;
    end else begin
      LNK_VALID <= beat_acc;
      LNK_DATA  <= TX.tdata;
      LNK_KEEP  <= TX.tkeep;
      LNK_LAST  <= pkt_end;
      LNK_CUT   <= cut_now;
    end
  end

  // store-and-forward packets are withdrawn before the link, cut-through ones
  // are already on the wire and can only be closed as bad
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      LNK_EP      <= 1'b0;
      LNK_DISCARD <= 1'b0;
      LNK_EDB     <= 1'b0;
    end else begin
      LNK_EP      <= pkt_end & poison_now;
      LNK_DISCARD <= pkt_end & ~cut_now & (dsc_hit | bad_now);
      LNK_EDB     <= pkt_end & cut_now & (dsc_hit | bad_now);
    end
  end

  // one pulse, the cycle after the end beat; a source discontinue is not a drop
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      err_drop_reg <= 1'b0;
    end else begin
      err_drop_reg <= pkt_end & bad_now;
    end
  end

endmodule

// [rtl/txfc_if.sv]
`timescale 1ns/1ps
interface txfc_if;
  logic                        tvalid;
  logic                        tready;
  logic [txfc_pkg::DATA_W-1:0] tdata;
  logic [txfc_pkg::KEEP_W-1:0] tkeep;
  logic                        tlast;
  logic [txfc_pkg::USER_W-1:0] tuser;
  logic                        cfg_req;
  logic                        cfg_gnt;
  logic                        err_drop;

  modport dev (
    input  tvalid,
    output tready,
    input  tdata,
    input  tkeep,
    input  tlast,
    input  tuser,
    output cfg_req,
    input  cfg_gnt,
    output err_drop
  );

  modport src (
    output tvalid,
    input  tready,
    output tdata,
    output tkeep,
    output tlast,
    output tuser,
    input  cfg_req,
    output cfg_gnt,
    input  err_drop
  );
endinterface

// [rtl/txfc_pkg.sv]
package txfc_pkg;

  localparam int DATA_W = 128;
  localparam int KEEP_W = 16;
  localparam int USER_W = 4;
  localparam int BEAT_W = 9;

  // sideband positions within tuser
  localparam int USER_FWD = 1;
  localparam int USER_STR = 2;
  localparam int USER_DSC = 3;

  localparam logic [KEEP_W-1:0] KEEP_FULL = 16'hFFFF;
  localparam logic [BEAT_W-1:0] BEATS_ZERO = 9'h000;
  localparam logic [BEAT_W-1:0] BEATS_ONE  = 9'h001;
  localparam logic [BEAT_W-1:0] BEATS_MAX  = 9'h1FF;

  // time the transmit path is lent to a self-generated packet
  localparam int CORE_PKT_NS = 20;
  localparam int CLK_PERIOD_NS = 5;
  localparam logic [7:0] CORE_PKT_CYCLES = 8'((CORE_PKT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] CYCLES_ZERO = 8'h00;
  localparam logic [7:0] CYCLES_ONE  = 8'h01;

  // avalon register map of the source end (byte addresses)
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFF_CTRL  = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_LEN   = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_STAT  = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_DROPS = 4'hC;

  localparam int CTRL_GO   = 0;
  localparam int CTRL_CUT  = 1;
  localparam int CTRL_FWD  = 2;
  localparam int CTRL_DSC  = 3;
  localparam int CTRL_GAP  = 4;
  localparam int CTRL_GNT  = 5;
  localparam int CTRL_W    = 6;

  localparam int STAT_BUSY  = 0;
  localparam int STAT_READY = 1;
  localparam int STAT_REQ   = 2;

  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
  localparam logic [BEAT_W-1:0] LEN_RESET  = 9'h001;
  localparam logic [15:0]       DROPS_ZERO = 16'h0000;
  localparam logic [31:0]       WORD_ZERO  = 32'h0000_0000;

  typedef enum logic [1:0] {
    TXFC_DEV_IDLE = 2'b00,
    TXFC_DEV_CORE = 2'b01
  } txfc_dev_state_type;

  typedef enum logic [1:0] {
    TXFC_SRC_IDLE  = 2'b00,
    TXFC_SRC_SEND  = 2'b01,
    TXFC_SRC_GRANT = 2'b11
  } txfc_src_state_type;

endpackage

// [rtl/txfc_source.sv]
`timescale 1ns/1ps
module txfc_source (
  input  wire logic                        SYS_CLK,
  input  wire logic                        RSTN,
  txfc_if.src                              TX,
  input  wire logic [txfc_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic                        AVS_READ,
  input  wire logic                        AVS_WRITE,
  input  wire logic [31:0]                 AVS_WRITEDATA,
  output logic [31:0]                      AVS_READDATA,
  output logic                             AVS_WAITREQUEST
);

  txfc_pkg::txfc_src_state_type state_reg;

  logic [txfc_pkg::CTRL_W-1:0] ctrl_reg;
  logic [txfc_pkg::BEAT_W-1:0] len_reg;
  logic [txfc_pkg::BEAT_W-1:0] left_reg;
  logic [15:0]                 drops_reg;
  logic                        gap_done_reg;
  logic                        tvalid_reg;
  logic                        tlast_reg;
  logic [txfc_pkg::USER_W-1:0] tuser_reg;
  logic [txfc_pkg::DATA_W-1:0] tdata_reg;
  logic                        gnt_reg;

  logic acc;
  logic done;
  logic go;
  logic wr_ok;
  logic rd_ok;
  logic last_next;
  logic [txfc_pkg::BEAT_W-1:0] left_next;

  assign TX.tvalid  = tvalid_reg;
  assign TX.tdata   = tdata_reg;
  assign TX.tkeep   = txfc_pkg::KEEP_FULL;
  assign TX.tlast   = tlast_reg;
  assign TX.tuser   = tuser_reg;
  assign TX.cfg_gnt = gnt_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then the access completes

  assign wr_ok = AVS_WRITE & ~AVS_WAITREQUEST;
  assign rd_ok = AVS_READ & ~AVS_WAITREQUEST;

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      AVS_WAITREQUEST <= ~((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST);
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      AVS_READDATA <= txfc_pkg::WORD_ZERO;
    end else if (AVS_READ && AVS_WAITREQUEST) begin
      case (AVS_ADDRESS)
        txfc_pkg::OFF_CTRL:  AVS_READDATA <= {26'h000_0000, ctrl_reg};
        txfc_pkg::OFF_LEN:   AVS_READDATA <= {23'h00_0000, len_reg};
        txfc_pkg::OFF_STAT:  AVS_READDATA <= {29'h0000_0000, TX.cfg_req, TX.tready,
                                              state_reg != txfc_pkg::TXFC_SRC_IDLE};
        txfc_pkg::OFF_DROPS: AVS_READDATA <= {16'h0000, drops_reg};
        default:             AVS_READDATA <= txfc_pkg::WORD_ZERO;
      endcase
    end
  end

  // go self-clears when the packet is launched
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_reg <= txfc_pkg::CTRL_RESET;
      len_reg  <= txfc_pkg::LEN_RESET;
    end else begin
      if (wr_ok && AVS_ADDRESS == txfc_pkg::OFF_CTRL) begin
        ctrl_reg <= AVS_WRITEDATA[txfc_pkg::CTRL_W-1:0];
      end else if (go) begin
        ctrl_reg[txfc_pkg::CTRL_GO] <= 1'b0;
      end
      if (wr_ok && AVS_ADDRESS == txfc_pkg::OFF_LEN && AVS_WRITEDATA[8:0] != 9'h000) begin
        len_reg <= AVS_WRITEDATA[txfc_pkg::BEAT_W-1:0];
      end
    end
  end

  // writing the drop counter clears it; a drop in the same cycle still counts
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      drops_reg <= txfc_pkg::DROPS_ZERO;
    end else if (TX.err_drop) begin
      drops_reg <= (wr_ok && AVS_ADDRESS == txfc_pkg::OFF_DROPS) ? 16'h0001 : drops_reg + 16'h0001;
    end else if (wr_ok && AVS_ADDRESS == txfc_pkg::OFF_DROPS) begin
      drops_reg <= txfc_pkg::DROPS_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // packet source: every packet starts on a fresh beat, signals held until taken

  assign acc       = tvalid_reg & TX.tready;
  assign done      = acc & tlast_reg;
  assign go        = (state_reg == txfc_pkg::TXFC_SRC_IDLE) & ctrl_reg[txfc_pkg::CTRL_GO];
  assign left_next = left_reg - txfc_pkg::BEATS_ONE;
  assign last_next = (left_next == txfc_pkg::BEATS_ONE);

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= txfc_pkg::TXFC_SRC_IDLE;
    end else begin
      case (state_reg)
        txfc_pkg::TXFC_SRC_IDLE:  if (go) state_reg <= txfc_pkg::TXFC_SRC_SEND;
        txfc_pkg::TXFC_SRC_SEND:  if (done) state_reg <= txfc_pkg::TXFC_SRC_GRANT;
        txfc_pkg::TXFC_SRC_GRANT: state_reg <= txfc_pkg::TXFC_SRC_IDLE;
        default:                  state_reg <= txfc_pkg::TXFC_SRC_IDLE;
      endcase
    end
  end

  // grant always, or one cycle after each own packet
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      gnt_reg <= 1'b0;
    end else begin
      gnt_reg <= ctrl_reg[txfc_pkg::CTRL_GNT] | done;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      tvalid_reg   <= 1'b0;
      tlast_reg    <= 1'b0;
      tuser_reg    <= '0;
      tdata_reg    <= '0;
      left_reg     <= txfc_pkg::BEATS_ZERO;
      gap_done_reg <= 1'b0;
    end else if (go) begin
      tvalid_reg   <= 1'b1;
      tlast_reg    <= (len_reg == txfc_pkg::BEATS_ONE);
      // poison request is not used for cut-through packets
      tuser_reg    <= {(len_reg == txfc_pkg::BEATS_ONE) ? 1'b0 : 1'b0,
                       ctrl_reg[txfc_pkg::CTRL_CUT],
                       ctrl_reg[txfc_pkg::CTRL_FWD] & ~ctrl_reg[txfc_pkg::CTRL_CUT], 1'b0};
      tdata_reg    <= {119'h0, len_reg};
      left_reg     <= len_reg;
      gap_done_reg <= 1'b0;
    end else if (acc) begin
      if (tlast_reg) begin
        tvalid_reg <= 1'b0;
        tlast_reg  <= 1'b0;
        tuser_reg  <= '0;
      end else begin
        // optional one-cycle gap mid-packet, used to exercise throttled cut-through
        tvalid_reg <= ~(ctrl_reg[txfc_pkg::CTRL_GAP] & ~gap_done_reg);
        tlast_reg  <= last_next;
        tuser_reg[txfc_pkg::USER_DSC] <= last_next & ctrl_reg[txfc_pkg::CTRL_DSC];
        tdata_reg  <= tdata_reg + 128'h1;
        left_reg   <= left_next;
      end
    end else if (state_reg == txfc_pkg::TXFC_SRC_SEND && !tvalid_reg) begin
      tvalid_reg   <= 1'b1;
      gap_done_reg <= 1'b1;
    end
  end

endmodule

// [verification/tb_tlp_tx_stream_flow_control.sv]
`timescale 1ns/1ps
`define CHK(g, e) chk(128'(g), 128'(e))
module tb_tlp_tx_stream_flow_control;
  typedef struct {int len; logic ep; logic dis; logic edb; logic cut;} txfc_exp_type;
  localparam logic [5:0] M_CUT = 6'(1 << txfc_pkg::CTRL_CUT);
  localparam logic [5:0] M_FWD = 6'(1 << txfc_pkg::CTRL_FWD);
  localparam logic [5:0] M_DSC = 6'(1 << txfc_pkg::CTRL_DSC);
  localparam logic [5:0] M_GAP = 6'(1 << txfc_pkg::CTRL_GAP);
  localparam logic [5:0] M_GNT = 6'(1 << txfc_pkg::CTRL_GNT);

  logic         SYS_CLK       = 1'h0;
  logic         RSTN          = 1'h0;
  logic         BUF_AVAIL     = 1'h1;
  logic         LINK_UP       = 1'h1;
  logic         PWR_D0        = 1'h1;
  logic         CORE_PKT_PEND = 1'h0;
  logic [8:0]   MAX_BEATS     = txfc_pkg::BEATS_MAX;
  logic [3:0]   AVS_ADDRESS   = 4'h0;
  logic         AVS_READ      = 1'h0;
  logic         AVS_WRITE     = 1'h0;
  logic [31:0]  AVS_WRITEDATA = 32'h0000_0000;
  logic [31:0]  AVS_READDATA;
  logic         AVS_WAITREQUEST;
  logic         LNK_VALID;
  logic [127:0] LNK_DATA;
  logic [15:0]  LNK_KEEP;
  logic         LNK_LAST, LNK_CUT, LNK_EP, LNK_DISCARD, LNK_EDB, CORE_PKT_SENT;
  txfc_exp_type exp_q[$];
  int           fail_count = 0;
  int           tests_run  = 0;
  int           exp_drops  = 0;
  int           drops_seen = 0;
  int           core_low   = 0;
  int           idx        = 0;

  always #2.5 SYS_CLK = ~SYS_CLK;

  txfc_if tx_if ();
  txfc_device i_txfc_device (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .TX(tx_if.dev),
    .BUF_AVAIL(BUF_AVAIL), .LINK_UP(LINK_UP), .PWR_D0(PWR_D0),
    .CORE_PKT_PEND(CORE_PKT_PEND), .MAX_BEATS(MAX_BEATS), .LNK_VALID(LNK_VALID),
    .LNK_DATA(LNK_DATA), .LNK_KEEP(LNK_KEEP), .LNK_LAST(LNK_LAST), .LNK_CUT(LNK_CUT),
    .LNK_EP(LNK_EP), .LNK_DISCARD(LNK_DISCARD), .LNK_EDB(LNK_EDB),
    .CORE_PKT_SENT(CORE_PKT_SENT));
  txfc_source i_txfc_source (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .TX(tx_if.src),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST));
  txfc_monitor i_txfc_monitor (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .tvalid(tx_if.tvalid),
    .tready(tx_if.tready), .tdata(tx_if.tdata), .tkeep(tx_if.tkeep),
    .tlast(tx_if.tlast), .tuser(tx_if.tuser), .cfg_req(tx_if.cfg_req),
    .cfg_gnt(tx_if.cfg_gnt), .err_drop(tx_if.err_drop));

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic hang();
    fail_count++;
    $display("wrong value at %0t: wait ran out", $time);
    tally_and_finish();
  endtask

  // request held until the edge that sees waitrequest low; data taken at that edge
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge SYS_CLK);
    AVS_ADDRESS   <= a;
    AVS_WRITE     <= wr;
    AVS_READ      <= !wr;
    AVS_WRITEDATA <= d;
    n = 0;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'h0 && n < 100);
    if (n >= 100) hang();
    q = AVS_READDATA;
    AVS_READ  <= 1'h0;
    AVS_WRITE <= 1'h0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    av(1'h1, a, d, q);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    av(1'h0, a, 32'h0000_0000, q);
  endtask

  // v holds the expected verdict: drop, end-bad, withdrawn, poison
  task automatic send(input int len, input logic [5:0] ctl, input logic [3:0] v,
                      input logic starve);
    txfc_exp_type e;
    logic [31:0]  q;
    int           n;
    e = '{len, v[0], v[1], v[2], ctl[txfc_pkg::CTRL_CUT]};
    exp_q.push_back(e);
    exp_drops += v[3];
    wr(txfc_pkg::OFF_LEN, 32'(len));
    wr(txfc_pkg::OFF_CTRL, 32'(ctl) | 32'h0000_0001);
    // the pool empties only once the first beat has been taken
    if (starve) begin
      n = 0;
      do begin
        @(posedge SYS_CLK);
        n++;
      end while (!(tx_if.tvalid === 1'h1 && tx_if.tready === 1'h1) && n < 20);
      if (n >= 20) hang();
      BUF_AVAIL <= 1'h0;
    end
    n = 0;
    do begin
      rd(txfc_pkg::OFF_STAT, q);
      n++;
    end while (q[txfc_pkg::STAT_BUSY] !== 1'h0 && n < 50);
    if (n >= 50) hang();
  endtask

  ////////////////////////////////////////////////////////////
  always @(posedge SYS_CLK) begin
    if (tx_if.err_drop === 1'h1) drops_seen++;
    if (CORE_PKT_PEND && tx_if.tready === 1'h0) core_low++;
    if (LNK_VALID === 1'h1 && exp_q.size() == 0) `CHK(LNK_VALID, 0);
    if (LNK_VALID === 1'h1 && exp_q.size() > 0) begin
      `CHK(LNK_DATA, exp_q[0].len + idx);
      `CHK(LNK_KEEP, txfc_pkg::KEEP_FULL);
      `CHK(LNK_CUT, exp_q[0].cut);
      idx++;
      if (LNK_LAST === 1'h1) begin
        `CHK(idx, exp_q[0].len);
        `CHK({LNK_EDB, LNK_DISCARD, LNK_EP}, {exp_q[0].edb, exp_q[0].dis, exp_q[0].ep});
        void'(exp_q.pop_front());
        idx = 0;
      end
    end
  end

  initial begin
    logic [31:0] q;
    int          n;
    void'($urandom(99));
    repeat (2) @(posedge SYS_CLK);
    RSTN <= 1'h1;
    rd(txfc_pkg::OFF_CTRL, q);
    `CHK(q, txfc_pkg::CTRL_RESET);
    rd(txfc_pkg::OFF_LEN, q);
    `CHK(q, txfc_pkg::LEN_RESET);
    wr(txfc_pkg::OFF_LEN, 32'h0000_0000);
    wr(4'h2, 32'hFFFF_FFFF);
    rd(4'h2, q);
    `CHK(q, 0);
    rd(txfc_pkg::OFF_LEN, q);
    `CHK(q, txfc_pkg::LEN_RESET);
    rd(txfc_pkg::OFF_STAT, q);
    `CHK(q[txfc_pkg::STAT_READY], 1);
    for (int i = 0; i < 4; i++) begin
      q = $urandom;
      send(1 + q[10:8] % 6, q[0] ? M_FWD : 6'h00, {3'h0, q[0]}, 1'h0);
    end
    send(3, M_CUT | M_FWD, 4'h0, 1'h0);
    send(3, M_DSC, 4'h2, 1'h0);
    send(3, M_CUT | M_DSC, 4'h4, 1'h0);
    send(4, M_CUT | M_GAP, 4'hC, 1'h0);
    send(4, M_GAP | M_FWD, 4'h1, 1'h0);
    @(posedge SYS_CLK) MAX_BEATS <= 9'h002;
    send(2, 6'h00, 4'h0, 1'h0);
    send(3, 6'h00, 4'hA, 1'h0);
    @(posedge SYS_CLK) MAX_BEATS <= txfc_pkg::BEATS_MAX;
    LINK_UP <= 1'h0;
    send(2, 6'h00, 4'hA, 1'h0);
    LINK_UP <= 1'h1;
    // buffers run out while the packet is on the wire: it must still finish
    send(5, 6'h00, 4'h0, 1'h1);
    rd(txfc_pkg::OFF_STAT, q);
    `CHK(q[txfc_pkg::STAT_READY], 0);
    BUF_AVAIL <= 1'h1;
    PWR_D0    <= 1'h0;
    repeat (3) @(posedge SYS_CLK);
    rd(txfc_pkg::OFF_STAT, q);
    `CHK(q[txfc_pkg::STAT_READY], 0);
    PWR_D0        <= 1'h1;
    CORE_PKT_PEND <= 1'h1;
    rd(txfc_pkg::OFF_STAT, q);
    `CHK(q[txfc_pkg::STAT_REQ], 1);
    `CHK(q[txfc_pkg::STAT_READY], 1);
    wr(txfc_pkg::OFF_CTRL, 32'(M_GNT));
    n = 0;
    while (CORE_PKT_SENT !== 1'h1 && n < 40) begin
      @(negedge SYS_CLK);
      n++;
    end
    if (n >= 40) hang();
    @(posedge SYS_CLK) CORE_PKT_PEND <= 1'h0;
    wr(txfc_pkg::OFF_CTRL, 32'h0000_0000);
    `CHK(core_low >= txfc_pkg::CORE_PKT_CYCLES && core_low <= 5, 1);
    n = 0;
    while (tx_if.tready !== 1'h1 && n < 40) begin
      @(negedge SYS_CLK);
      n++;
    end
    `CHK(tx_if.tready, 1);
    rd(txfc_pkg::OFF_DROPS, q);
    `CHK(q, exp_drops);
    `CHK(drops_seen, exp_drops);
    wr(txfc_pkg::OFF_DROPS, 32'h0000_0000);
    rd(txfc_pkg::OFF_DROPS, q);
    `CHK(q, 0);
    `CHK(exp_q.size(), 0);
    tally_and_finish();
  end
endmodule

// [verification/txfc_monitor.sv]
`timescale 1ns/1ps
module txfc_monitor (
  input wire logic         SYS_CLK,
  input wire logic         RSTN,
  input wire logic         tvalid,
  input wire logic         tready,
  input wire logic [127:0] tdata,
  input wire logic [15:0]  tkeep,
  input wire logic         tlast,
  input wire logic [3:0]   tuser,
  input wire logic         cfg_req,
  input wire logic         cfg_gnt,
  input wire logic         err_drop
);
  logic       in_pkt_reg;
  logic       cut_reg;
  logic       gap_reg;
  logic [2:0] end_hist_reg;
  logic       acc;
  logic       end_beat;

  assign acc = tvalid & tready;
  // discontinue on a first beat is ignored, so it never ends a packet
  assign end_beat = acc & (tlast | (in_pkt_reg & tuser[txfc_pkg::USER_DSC]));

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) in_pkt_reg <= 1'h0;
    else if (acc) in_pkt_reg <= !end_beat;
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) cut_reg <= 1'h0;
    else if (acc & !in_pkt_reg) cut_reg <= tuser[txfc_pkg::USER_STR];
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) gap_reg <= 1'h0;
    else if (end_beat) gap_reg <= 1'h0;
    else if (in_pkt_reg & cut_reg & !tvalid) gap_reg <= 1'h1;
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) end_hist_reg <= 3'h0;
    else end_hist_reg <= {end_hist_reg[1:0], end_beat};
  end

  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  a_ready_in_pkt: assert property (in_pkt_reg |-> tready)
    else $error("ready withdrawn inside a packet");
  a_drop_one_pulse: assert property (err_drop |=> !err_drop)
    else $error("drop flag longer than one cycle");
  a_drop_after_end: assert property (err_drop |-> |end_hist_reg)
    else $error("drop flag without a recent packet end");
  a_gap_cut_drop: assert property (end_beat && gap_reg |-> ##[1:3] err_drop)
    else $error("throttled cut-through packet not dropped");
  a_hold_stalled: assert property (tvalid && !tready |=>
    tvalid && $stable(tdata) && $stable(tuser) && $stable(tlast))
    else $error("source changed a stalled beat");
  a_no_first_dsc: assert property (tvalid && !in_pkt_reg |-> !tuser[3])
    else $error("discontinue on a first beat");
  a_no_cut_poison: assert property (tvalid && tuser[2] |-> !tuser[1])
    else $error("poison request in cut-through mode");
  a_cut_whole_pkt: assert property (tvalid && in_pkt_reg |-> tuser[2] == cut_reg)
    else $error("cut-through flag changed mid packet");
  a_grant_after_end: assert property (end_beat |-> ##1 cfg_gnt)
    else $error("no grant after packet end");
  a_start_low_dw: assert property (tvalid && !in_pkt_reg |-> tkeep[3:0] == 4'hF)
    else $error("packet does not start in lowest word");

  c_discontinue: cover property (end_beat && in_pkt_reg && tuser[3]);
  c_drop: cover property (err_drop);
  c_core_send: cover property (cfg_req && cfg_gnt ##1 !tready);
endmodule
